// ==== rtl/sls_pkg.sv ====
package sls_pkg;

    // ==========================================================
    // Register indices (byte address = 4 * index)
    localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
    localparam logic [11:0] IDX_ERR_THRESHOLD = 12'h301;
    localparam logic [11:0] IDX_CNT_HOLD = 12'h302;
    localparam logic [11:0] IDX_CNT_CLEAR = 12'h303;
    localparam logic [11:0] IDX_INT_STATUS = 12'h304;
    localparam logic [11:0] IDX_INT_ENABLE = 12'h305;
    localparam logic [11:0] IDX_INT_CLEAR = 12'h306;
    localparam logic [11:0] IDX_LANE0_LINK_STATUS = 12'h4B0;
    localparam logic [11:0] IDX_LANE1_LINK_STATUS = 12'h4B1;
    localparam logic [11:0] IDX_LANE2_LINK_STATUS = 12'h4B2;
    localparam int IDX_LSB = 2;

    // ==========================================================
    // Error counters
    localparam int CNT_W = 8;
    localparam int NUM_ERR = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_TERMINAL = 8'hFF;
    localparam logic [CNT_W-1:0] THRESHOLD_RESET = 8'hFF;
    localparam int ERR_DISP = 0;
    localparam int ERR_INV = 1;
    localparam int ERR_KCHAR = 2;

    // ==========================================================
    // Lane status field positions
    localparam int BIT_DISP = 7;
    localparam int BIT_INV = 6;
    localparam int BIT_KCHAR = 5;
    localparam int BIT_DESKEW = 4;
    localparam int BIT_ILA = 3;
    localparam int BIT_CKS = 2;
    localparam int BIT_FRAME = 1;
    localparam int BIT_CGS = 0;

    // One-cycle error events from a lane decoder
    typedef struct packed {
        logic kchar;
        logic inv;
        logic disp;
    } sls_err_s;

    // Lane synchronisation levels, packed in status bit order 4..0
    typedef struct packed {
        logic deskew;
        logic ila;
        logic cks;
        logic frame;
        logic cgs;
    } sls_sync_s;

endpackage

// ==== rtl/sls_lane_status.sv ====
// Overview of operation
// RULE1 - Error flag set when count reaches threshold
// RULE2 - Bit 7 flags disparity errors
// RULE3 - Bit 6 flags not-in-table symbols
// RULE4 - Bit 5 flags misplaced control characters
// RULE5 - Bit 4 reports interlane deskew
// RULE6 - Bit 3 reports initial lane alignment
// RULE7 - Bit 2 reports configuration checksum result
// RULE8 - Bit 1 reports frame alignment
// RULE9 - Bit 0 reports code group sync
// RULE10 - Fields show link chosen by page control
// RULE11 - 8-bit counters hold or roll at 0xFF
// RULE12 - Lane 0 at 0x4B0, lanes consecutive
// RULE13 - Status resets zero, ignores writes
`timescale 1ns/10ps
module sls_lane_status #(
    parameter int NUM_LINKS = 2,
    parameter int NUM_LANES = 3,
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver lanes, index = link * NUM_LANES + lane
    input wire sls_pkg::sls_err_s [NUM_LINKS*NUM_LANES-1:0] err_evt,
    input wire sls_pkg::sls_sync_s [NUM_LINKS*NUM_LANES-1:0] sync_state,
    // Interrupt
    output logic irq
);

    localparam int NL = NUM_LINKS * NUM_LANES;
    localparam int LINK_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

    // All checks below share the system clock and reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Bus decode
    logic [11:0] idx;
    logic access;
    logic done;
    logic wr_done;
    logic [LINK_W-1:0] link_page;
    logic [sls_pkg::CNT_W-1:0] err_threshold;
    logic [sls_pkg::NUM_ERR-1:0] counter_hold_at_max;
    logic [sls_pkg::NUM_ERR-1:0] cnt_clear;
    logic [NUM_LANES-1:0] int_status;
    logic [NUM_LANES-1:0] int_enable;
    logic [NUM_LANES-1:0] int_clear;
    logic [NUM_LANES-1:0] flag_rise;
    logic [sls_pkg::CNT_W-1:0] cnt [NL][sls_pkg::NUM_ERR];
    logic [sls_pkg::NUM_ERR-1:0] flag [NL];
    logic [31:0] next_prdata;
    logic next_err;

    assign idx = paddr[sls_pkg::IDX_LSB +: 12];
    // One wait state: pready is raised in the second access cycle
    assign access = psel & penable & ~pready;
    assign done = psel & penable & pready;
    assign wr_done = done & pwrite & ~pslverr;
    assign cnt_clear = (wr_done && idx == sls_pkg::IDX_CNT_CLEAR) ?
        pwdata[sls_pkg::NUM_ERR-1:0] : '0;
    assign int_clear = (wr_done && idx == sls_pkg::IDX_INT_CLEAR) ?
        pwdata[NUM_LANES-1:0] : '0;

    // ==========================================================
    // Read mux
    always_comb begin
        int li;
        logic [11:0] lane_off;
        li = 0;
        lane_off = idx - sls_pkg::IDX_LANE0_LINK_STATUS;
        next_prdata = '0;
        next_err = 1'b0;
        case (idx)
            sls_pkg::IDX_LINK_PAGE: next_prdata[LINK_W-1:0] = link_page;
            sls_pkg::IDX_ERR_THRESHOLD: next_prdata[sls_pkg::CNT_W-1:0] = err_threshold;
            sls_pkg::IDX_CNT_HOLD: next_prdata[sls_pkg::NUM_ERR-1:0] = counter_hold_at_max;
            sls_pkg::IDX_CNT_CLEAR: next_prdata = '0;
            sls_pkg::IDX_INT_STATUS: next_prdata[NUM_LANES-1:0] = int_status;
            sls_pkg::IDX_INT_ENABLE: next_prdata[NUM_LANES-1:0] = int_enable;
            sls_pkg::IDX_INT_CLEAR: next_prdata = '0;
            default: begin
                // RULE12 lane address map
                if (idx >= sls_pkg::IDX_LANE0_LINK_STATUS &&
                    int'(lane_off) < NUM_LANES) begin
                    // RULE10 paged by link
                    li = int'(link_page) * NUM_LANES + int'(lane_off);
                    // Page past the last link reads as zero
                    if (int'(link_page) < NUM_LINKS) begin
                        // RULE2 disparity flag
                        next_prdata[sls_pkg::BIT_DISP] = flag[li][sls_pkg::ERR_DISP];
                        // RULE3 invalid code flag
                        next_prdata[sls_pkg::BIT_INV] = flag[li][sls_pkg::ERR_INV];
                        // RULE4 control char flag
                        next_prdata[sls_pkg::BIT_KCHAR] = flag[li][sls_pkg::ERR_KCHAR];
                        // RULE5 deskew status
                        next_prdata[sls_pkg::BIT_DESKEW] = sync_state[li].deskew;
                        // RULE6 lane alignment status
                        next_prdata[sls_pkg::BIT_ILA] = sync_state[li].ila;
                        // RULE7 checksum status
                        next_prdata[sls_pkg::BIT_CKS] = sync_state[li].cks;
                        // RULE8 frame status
                        next_prdata[sls_pkg::BIT_FRAME] = sync_state[li].frame;
                        // RULE9 code group status
                        next_prdata[sls_pkg::BIT_CGS] = sync_state[li].cgs;
                    end
                end else begin
                    next_err = 1'b1;
                end
            end
        endcase
    end

    // ==========================================================
    // APB handshake
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= access;
            pslverr <= access & next_err;
            if (access) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            end
        end
    end

    // ==========================================================
    // Control registers
    // RULE13 status words have no write path
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link_page <= '0;
            err_threshold <= sls_pkg::THRESHOLD_RESET;
            counter_hold_at_max <= '0;
            int_enable <= '0;
        end else if (wr_done) begin
            case (idx)
                sls_pkg::IDX_LINK_PAGE: link_page <= pwdata[LINK_W-1:0];
                sls_pkg::IDX_ERR_THRESHOLD: err_threshold <= pwdata[sls_pkg::CNT_W-1:0];
                sls_pkg::IDX_CNT_HOLD: counter_hold_at_max <= pwdata[sls_pkg::NUM_ERR-1:0];
                sls_pkg::IDX_INT_ENABLE: int_enable <= pwdata[NUM_LANES-1:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Error counters
    // RULE11 hold or roll at terminal count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NL; i++) begin
                for (int t = 0; t < sls_pkg::NUM_ERR; t++) begin
                    cnt[i][t] <= sls_pkg::CNT_ZERO;
                end
            end
        end else begin
            for (int i = 0; i < NL; i++) begin
                for (int t = 0; t < sls_pkg::NUM_ERR; t++) begin
                    // Software clear beats a same-cycle event
                    if (cnt_clear[t] && (i / NUM_LANES) == int'(link_page)) begin
                        cnt[i][t] <= sls_pkg::CNT_ZERO;
                    end else if (err_evt[i][t]) begin
                        if (cnt[i][t] != sls_pkg::CNT_TERMINAL) begin
                            cnt[i][t] <= cnt[i][t] + sls_pkg::CNT_ONE;
                        end else if (!counter_hold_at_max[t]) begin
                            cnt[i][t] <= sls_pkg::CNT_ZERO;
                        end
                    end
                end
            end
        end
    end

    // RULE1 threshold compare
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NL; i++) begin
                flag[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NL; i++) begin
                for (int t = 0; t < sls_pkg::NUM_ERR; t++) begin
                    flag[i][t] <= (cnt[i][t] >= err_threshold);
                end
            end
        end
    end

    // ==========================================================
    // Interrupts
    // A flag going high on any link raises the bit of its lane
    always_comb begin
        flag_rise = '0;
        for (int i = 0; i < NL; i++) begin
            for (int t = 0; t < sls_pkg::NUM_ERR; t++) begin
                if (cnt[i][t] >= err_threshold && !flag[i][t]) begin
                    flag_rise[i % NUM_LANES] = 1'b1;
                end
            end
        end
    end

    // New event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~int_clear) | flag_rise;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_enable);
        end
    end

    // ==========================================================
    // Assertions
    sequence s_lane0_read;
        access && !pwrite && idx == sls_pkg::IDX_LANE0_LINK_STATUS && link_page == '0;
    endsequence

    sequence s_lane0_write;
        access && pwrite && idx == sls_pkg::IDX_LANE0_LINK_STATUS;
    endsequence

    property p_thr_at_or_above;
        cnt[0][sls_pkg::ERR_DISP] >= err_threshold |=> flag[0][sls_pkg::ERR_DISP];
    endproperty
    a_thr_at_or_above: assert property (p_thr_at_or_above) // RULE1
        else $error("flag low with count at threshold");

    property p_thr_below;
        cnt[0][sls_pkg::ERR_INV] < err_threshold |=> !flag[0][sls_pkg::ERR_INV];
    endproperty
    a_thr_below: assert property (p_thr_below) // RULE1
        else $error("flag high with count below threshold");

    property p_kchar_thr;
        cnt[NL-1][sls_pkg::ERR_KCHAR] >= err_threshold |=> flag[NL-1][sls_pkg::ERR_KCHAR];
    endproperty
    a_kchar_thr: assert property (p_kchar_thr) // RULE1
        else $error("control char flag low with count at threshold");

    property p_disp_bit;
        s_lane0_read |=> pready && prdata[sls_pkg::BIT_DISP] == $past(flag[0][sls_pkg::ERR_DISP]);
    endproperty
    a_disp_bit: assert property (p_disp_bit) // RULE2
        else $error("disparity flag misplaced");

    property p_inv_bit;
        s_lane0_read |=> prdata[sls_pkg::BIT_INV] == $past(flag[0][sls_pkg::ERR_INV]);
    endproperty
    a_inv_bit: assert property (p_inv_bit) // RULE3
        else $error("invalid code flag misplaced");

    property p_kchar_bit;
        s_lane0_read |=> prdata[sls_pkg::BIT_KCHAR] == $past(flag[0][sls_pkg::ERR_KCHAR]);
    endproperty
    a_kchar_bit: assert property (p_kchar_bit) // RULE4
        else $error("control char flag misplaced");

    property p_sync_bits;
        s_lane0_read |=> prdata[sls_pkg::BIT_DESKEW:sls_pkg::BIT_CGS] == $past(sync_state[0]);
    endproperty
    a_sync_bits: assert property (p_sync_bits) // RULE5 RULE6 RULE7 RULE8 RULE9
        else $error("sync status bits wrong");

    property p_frame_bit;
        s_lane0_read |=> prdata[sls_pkg::BIT_FRAME] == $past(sync_state[0].frame);
    endproperty
    a_frame_bit: assert property (p_frame_bit) // RULE8
        else $error("frame status bit wrong");

    generate
        if (NUM_LINKS > 1) begin : g_page
            property p_page;
                access && !pwrite && idx == sls_pkg::IDX_LANE0_LINK_STATUS &&
                    link_page == LINK_W'(1) |=>
                    prdata[sls_pkg::BIT_DISP] == $past(flag[NUM_LANES][sls_pkg::ERR_DISP]) &&
                    prdata[sls_pkg::BIT_CGS] == $past(sync_state[NUM_LANES].cgs);
            endproperty
            a_page: assert property (p_page) // RULE10
                else $error("paged read returned wrong link");
        end
        if (NUM_LANES > 1) begin : g_lane1
            property p_lane1_addr;
                access && !pwrite && idx == sls_pkg::IDX_LANE1_LINK_STATUS &&
                    link_page == '0 |=> !pslverr &&
                    prdata[sls_pkg::BIT_CKS] == $past(sync_state[1].cks);
            endproperty
            a_lane1_addr: assert property (p_lane1_addr) // RULE12
                else $error("lane 1 address decode wrong");
        end
    endgenerate

    property p_cnt_hold;
        cnt[0][sls_pkg::ERR_DISP] == sls_pkg::CNT_TERMINAL && err_evt[0].disp &&
            counter_hold_at_max[sls_pkg::ERR_DISP] && !cnt_clear[sls_pkg::ERR_DISP] |=>
            cnt[0][sls_pkg::ERR_DISP] == sls_pkg::CNT_TERMINAL;
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) // RULE11
        else $error("counter did not hold at terminal count");

    property p_cnt_roll;
        cnt[0][sls_pkg::ERR_DISP] == sls_pkg::CNT_TERMINAL && err_evt[0].disp &&
            !counter_hold_at_max[sls_pkg::ERR_DISP] && !cnt_clear[sls_pkg::ERR_DISP] |=>
            cnt[0][sls_pkg::ERR_DISP] == sls_pkg::CNT_ZERO;
    endproperty
    a_cnt_roll: assert property (p_cnt_roll) // RULE11
        else $error("counter did not roll over");

    property p_status_write_ignored;
        s_lane0_write |=> !pslverr ##1 $stable(link_page) && $stable(err_threshold);
    endproperty
    a_status_write_ignored: assert property (p_status_write_ignored) // RULE13
        else $error("write to status word had an effect");

    property p_irq;
        |(int_status & int_enable) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

endmodule

// ==== sim/sls_lane_model.sv ====
`timescale 1ns/10ps
module sls_lane_model #(
    parameter int NL = 6
) (
    // Clock
    input wire logic clk_sys,
    // Lane decoder outputs
    output sls_pkg::sls_err_s [NL-1:0] err_evt,
    output sls_pkg::sls_sync_s [NL-1:0] sync_state
);
    // ==========================================================
    // Lane decoder behaviour
    initial begin
        err_evt = '0;
        sync_state = '0;
    end

    // Back-to-back beats: one event per cycle while high
    task automatic send_err(input int lane, input int kind, input int n);
        @(posedge clk_sys);
        err_evt[lane][kind] <= 1'b1;
        repeat (n) @(posedge clk_sys);
        err_evt[lane][kind] <= 1'b0;
    endtask

    task automatic set_sync(input int lane, input logic [4:0] val);
        @(posedge clk_sys);
        sync_state[lane] <= val;
    endtask
endmodule

// ==== sim/test_sls_lane_status.sv ====
`timescale 1ns/10ps
module test_sls_lane_status;
    logic clk_sys;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    sls_pkg::sls_err_s [5:0] err_evt;
    sls_pkg::sls_sync_s [5:0] sync_state;
    int fail_count = 0;
    int check_count = 0;

    sls_lane_status #(.NUM_LINKS(2), .NUM_LANES(3), .ADDR_W(14)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .err_evt(err_evt), .sync_state(sync_state), .irq(irq)
    );

    sls_lane_model #(.NL(6)) partner_u (
        .clk_sys(clk_sys), .err_evt(err_evt), .sync_state(sync_state)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Bus and checking tasks
    task automatic test_done();
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            test_done();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        check(what, r, exp);
    endtask

    // Level output lags its cause by one register stage
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_sys);
        #1;
        check("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    // ==========================================================
    // Scenarios
    task automatic sc_reset_ro();
        logic [31:0] r;
        logic e;
        for (int l = 0; l < 3; l++) begin
            rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS + 12'(l), 32'h0, "reset");
        end
        partner_u.set_sync(0, 5'h15);
        apb(1'b1, sls_pkg::IDX_LANE0_LINK_STATUS, 32'hFFFFFFFF, r, e);
        check("ro_err", {31'h0, e}, 32'h0);
        rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS, 32'h15, "ro_keep");
        apb(1'b0, 12'h3FF, 32'h0, r, e);
        check("unmapped", {31'h0, e}, 32'h1);
    endtask

    task automatic sc_sync_bits();
        for (int b = 0; b < 5; b++) begin
            partner_u.set_sync(1, 5'(1 << b));
            rd_chk(sls_pkg::IDX_LANE1_LINK_STATUS, 32'(1 << b), "sync");
        end
    endtask

    task automatic sc_paging();
        logic [4:0] v [6] = '{5'h01, 5'h02, 5'h04, 5'h10, 5'h08, 5'h1F};
        for (int i = 0; i < 6; i++) begin
            partner_u.set_sync(i, v[i]);
        end
        for (int k = 0; k < 2; k++) begin
            wr(sls_pkg::IDX_LINK_PAGE, 32'(k));
            for (int l = 0; l < 3; l++) begin
                rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS + 12'(l), 32'(v[k*3+l]), "page");
            end
        end
        wr(sls_pkg::IDX_LINK_PAGE, 32'h0);
    endtask

    task automatic sc_threshold();
        partner_u.set_sync(2, 5'h0);
        wr(sls_pkg::IDX_CNT_CLEAR, 32'h7);
        wr(sls_pkg::IDX_ERR_THRESHOLD, 32'h3);
        for (int k = 0; k < 3; k++) begin
            partner_u.send_err(2, k, 2);
            rd_chk(sls_pkg::IDX_LANE2_LINK_STATUS, 32'h0, "below");
            partner_u.send_err(2, k, 1);
            rd_chk(sls_pkg::IDX_LANE2_LINK_STATUS, 32'h80 >> k, "at");
            wr(sls_pkg::IDX_CNT_CLEAR, 32'h7);
        end
    endtask

    task automatic sc_terminal();
        wr(sls_pkg::IDX_ERR_THRESHOLD, 32'hFF);
        for (int h = 1; h >= 0; h--) begin
            wr(sls_pkg::IDX_CNT_HOLD, 32'(h * 7));
            wr(sls_pkg::IDX_CNT_CLEAR, 32'h7);
            partner_u.send_err(0, 0, 255);
            rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS, 32'h81, "terminal");
            partner_u.send_err(0, 0, 1);
            rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS, h ? 32'h81 : 32'h01, "hold_wrap");
        end
    endtask

    task automatic sc_irq();
        wr(sls_pkg::IDX_CNT_CLEAR, 32'h7);
        wr(sls_pkg::IDX_ERR_THRESHOLD, 32'h1);
        wr(sls_pkg::IDX_INT_CLEAR, 32'h7);
        wr(sls_pkg::IDX_INT_ENABLE, 32'h2);
        rd_chk(sls_pkg::IDX_INT_STATUS, 32'h0, "int_idle");
        irq_chk(1'b0);
        partner_u.send_err(1, 1, 1);
        rd_chk(sls_pkg::IDX_INT_STATUS, 32'h2, "int_set");
        irq_chk(1'b1);
        wr(sls_pkg::IDX_INT_ENABLE, 32'h0);
        irq_chk(1'b0);
        wr(sls_pkg::IDX_INT_ENABLE, 32'h2);
        irq_chk(1'b1);
        wr(sls_pkg::IDX_INT_CLEAR, 32'h2);
        rd_chk(sls_pkg::IDX_INT_STATUS, 32'h0, "int_clr");
        irq_chk(1'b0);
    endtask

    // Flags follow the page too, not only the sync levels
    task automatic sc_regs();
        wr(sls_pkg::IDX_LINK_PAGE, 32'h1);
        rd_chk(sls_pkg::IDX_LINK_PAGE, 32'h1, "page_rb");
        partner_u.send_err(3, 0, 1);
        rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS, 32'h90, "page_flag1");
        wr(sls_pkg::IDX_LINK_PAGE, 32'h0);
        rd_chk(sls_pkg::IDX_LANE0_LINK_STATUS, 32'h01, "page_flag0");
        wr(sls_pkg::IDX_ERR_THRESHOLD, 32'h5A);
        rd_chk(sls_pkg::IDX_ERR_THRESHOLD, 32'h5A, "thr_rb");
        wr(sls_pkg::IDX_CNT_HOLD, 32'h5);
        rd_chk(sls_pkg::IDX_CNT_HOLD, 32'h5, "hold_rb");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h00000000;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        sc_reset_ro();
        sc_sync_bits();
        sc_paging();
        sc_threshold();
        sc_terminal();
        sc_irq();
        sc_regs();
        test_done();
    end
endmodule
